// [pkg/i2cs_regs.vh]
`ifndef I2CS_REGS_VH
`define I2CS_REGS_VH

// ------------------------------------------------------------
// Slave address
// ------------------------------------------------------------
// 7-bit address is {I2CS_ADDR7_HI, select bits}: 40h..47h
`define I2CS_ADDR7_HI 4'h8
// First byte of a 10-bit address opens with this prefix
`define I2CS_TEN_PREFIX 5'h1e
// 10-bit address is {HI, MID, select bits}
`define I2CS_ADDR10_HI 2'h0
`define I2CS_ADDR10_MID 5'h08

// ------------------------------------------------------------
// General call
// ------------------------------------------------------------
`define I2CS_GC_ADDR 8'h00
`define I2CS_GC_RESET 8'h06
`define I2CS_GC_LATCH 8'h04

// ------------------------------------------------------------
// Register address ranges that advance after each byte
// ------------------------------------------------------------
`define I2CS_INC_A_LO 8'h00
`define I2CS_INC_A_HI 8'h07
`define I2CS_INC_B_LO 8'h10
`define I2CS_INC_B_HI 8'h1f
`define I2CS_INC_C_LO 8'h30
`define I2CS_INC_C_HI 8'h37
`define I2CS_INC_D_LO 8'h60
`define I2CS_INC_D_HI 8'h77
`define I2CS_INC_E_LO 8'h80
`define I2CS_INC_E_HI 8'hbf
// Range that holds the address still
`define I2CS_FIX_LO 8'h38
`define I2CS_FIX_HI 8'h3f

// ------------------------------------------------------------
// Sizes and reset values
// ------------------------------------------------------------
`define I2CS_DATA_W 8
`define I2CS_FIFO_DEPTH 16
`define I2CS_FIFO_AW 4
`define I2CS_REG_ADDR_RST 8'h00
`define I2CS_BITS_PER_BYTE 4'h8

`endif

// [rtl/i2cs_fifo.v]
`timescale 1ns/1ns
`default_nettype none

module i2cs_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Filling side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output reg in_ready,
	// Draining side
	output reg out_valid,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	reg [AW:0] next_count;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_ptr];

	// ------------------------------------------------------------
	// Occupancy
	// ------------------------------------------------------------
	always @* begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 1'b1;
		else if (pop & ~push)
			next_count = count - 1'b1;
	end

	// Flags kept as flops so both sides see clean levels
	always @(posedge clk_sys) begin
		if (!nrst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			in_ready <= (next_count != DEPTH[AW:0]);
			out_valid <= (next_count != {(AW+1){1'b0}});
		end
	end

	// Storage has no reset; only written words are ever read
	always @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

endmodule

`default_nettype wire

// [rtl/i2cs_slave.v]
// Function
// R1 - Registers are 8 bits, one per address
// R2 - Address 38h-3Fh stays fixed during bursts
// R3 - Listed ranges advance address after each byte
// R4 - Slave only, standard and fast rates
// R5 - Match both 7-bit and 10-bit addressing
// R6 - Select bits give addresses 40h to 47h
// R7 - Latch select bits at reset only; the code also relatches them on general call 04h/06h
// R8 - Select bits shared with general-purpose pins
// R9 - Start: data falls while clock high
// R10 - Ignore everything until a start
// R11 - Stop: data rises while clock high, idle
// R12 - Master ends read with no-ack, stop
// R13 - Stop after write stores no more bytes
// R14 - Receiver acknowledges on ninth clock
// R15 - Sample data on rising clock edge
// R16 - Master opens with address and direction
// R17 - Ack on match, else release and ignore
// R18 - Write: address, register, data, stop
// R19 - Read: repeated start, bytes until stop
// R20 - Ack and commit each byte in order
`timescale 1ns/1ns
`default_nettype none
`include "i2cs_regs.vh"

module i2cs_slave (
	// Clock and reset
	input wire clk_sys,
	input wire nrst,
	// Serial bus, open drain, enable low drives low
	input wire scl_in,
	output reg scl_oe_n,
	input wire serial_data_pin_in,
	output reg serial_data_pin_oe_n,
	// Address select, shared with general-purpose pins
	input wire addr_select_bit2,
	input wire addr_select_bit1,
	input wire addr_select_bit0,
	// Register write stream
	output wire wr_valid,
	output wire [7:0] wr_addr,
	output wire [7:0] wr_data,
	input wire wr_ready,
	// Register read port
	output reg [7:0] rd_addr,
	output reg rd_strobe,
	input wire [7:0] rd_data
);

	// ------------------------------------------------------------
	// States and byte kinds
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'd0;
	localparam ST_RX = 3'd1;
	localparam ST_ACK = 3'd2;
	localparam ST_HOLD = 3'd3;
	localparam ST_TX = 3'd4;
	localparam ST_MACK = 3'd5;

	localparam K_NONE = 3'd0;
	localparam K_ADDR = 3'd1;
	localparam K_ADDR2 = 3'd2;
	localparam K_REG = 3'd3;
	localparam K_DATA = 3'd4;
	localparam K_GC = 3'd5;
	localparam K_READ = 3'd6;

	reg [2:0] state;
	reg [2:0] kind;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg [7:0] txd;
	reg ten_ok;
	reg fifo_push;
	reg [15:0] fifo_wdata;
	wire fifo_in_ready;
	wire [15:0] fifo_out;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	reg scl_s1, scl_s2, scl_d;
	reg sda_s1, sda_s2, sda_d;
	reg [2:0] sel_s1, sel_s2;
	reg [2:0] sel;
	reg sel_relatch;

	// Two flops per pin, third stage only for edge finding
	always @(posedge clk_sys) begin
		scl_s1 <= scl_in;
		scl_s2 <= scl_s1;
		sda_s1 <= serial_data_pin_in;
		sda_s2 <= sda_s1;
		sel_s1 <= {addr_select_bit2, addr_select_bit1, addr_select_bit0};
		sel_s2 <= sel_s1;
	end

	// Edge history, held high in reset like an idle bus
	always @(posedge clk_sys) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s2;
			sda_d <= sda_s2;
		end
	end

	wire scl_rise = scl_s2 & ~scl_d; // R4
	wire scl_fall = ~scl_s2 & scl_d;
	// Our own data changes only while the clock is low, so no false hits
	wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2; // R9
	wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2; // R11

	// ------------------------------------------------------------
	// Select bits: caught while reset is held and again on general call 04h/06h
	// ------------------------------------------------------------
	// The pins only need to be steady for the last few reset cycles
	always @(posedge clk_sys) begin
		if (!nrst)
			sel <= sel_s2; // R7 R8
		else if (sel_relatch)
			sel <= sel_s2; // R7
	end

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	wire match7 = (shreg[7:1] == {`I2CS_ADDR7_HI, sel}); // R6
	wire ten_first = (shreg[7:3] == `I2CS_TEN_PREFIX) &&
		(shreg[2:1] == `I2CS_ADDR10_HI);
	wire ten_second = (shreg == {`I2CS_ADDR10_MID, sel});
	wire is_gc = (shreg == `I2CS_GC_ADDR);
	wire gc_known = (shreg == `I2CS_GC_RESET) || (shreg == `I2CS_GC_LATCH);
	wire byte_done = (bit_cnt == `I2CS_BITS_PER_BYTE);

	// Whether the address moves on after a byte at this address
	function addr_steps;
		input [7:0] a;
		begin
			if (a >= `I2CS_FIX_LO && a <= `I2CS_FIX_HI)
				addr_steps = 1'b0; // R2
			else
				addr_steps = (a <= `I2CS_INC_A_HI) ||
					(a >= `I2CS_INC_B_LO && a <= `I2CS_INC_B_HI) ||
					(a >= `I2CS_INC_C_LO && a <= `I2CS_INC_C_HI) ||
					(a >= `I2CS_INC_D_LO && a <= `I2CS_INC_D_HI) ||
					(a >= `I2CS_INC_E_LO && a <= `I2CS_INC_E_HI); // R3
		end
	endfunction

	// ------------------------------------------------------------
	// Byte engine
	// ------------------------------------------------------------
	// Bus-only timing: every step but the ST_HOLD release waits on a clock or data edge from the master,
	// so any rate up to fast mode is followed at this sampling rate
	always @(posedge clk_sys) begin
		if (!nrst) begin
			state <= ST_IDLE;
			kind <= K_NONE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			txd <= 8'h00;
			ten_ok <= 1'b0;
			scl_oe_n <= 1'b1;
			serial_data_pin_oe_n <= 1'b1;
			rd_addr <= `I2CS_REG_ADDR_RST;
			rd_strobe <= 1'b0;
			fifo_push <= 1'b0;
			fifo_wdata <= 16'h0000;
			sel_relatch <= 1'b0;
		end else begin
			rd_strobe <= 1'b0;
			fifo_push <= 1'b0;
			sel_relatch <= 1'b0;
			if (start_det) begin
				// Start or repeated start: a fresh address byte follows
				state <= ST_RX; // R10
				kind <= K_ADDR;
				bit_cnt <= 4'h0;
				serial_data_pin_oe_n <= 1'b1;
				scl_oe_n <= 1'b1;
			end else if (stop_det) begin
				// Ends any write; nothing more is pushed
				state <= ST_IDLE; // R11 R13
				kind <= K_NONE;
				ten_ok <= 1'b0;
				serial_data_pin_oe_n <= 1'b1;
				scl_oe_n <= 1'b1;
			end else begin
				case (state)
				ST_IDLE: begin
					// Deaf until the next start
					serial_data_pin_oe_n <= 1'b1; // R10
					scl_oe_n <= 1'b1;
				end
				ST_RX: begin
					if (scl_rise && !byte_done) begin
						shreg <= {shreg[6:0], sda_s2}; // R15
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done) begin
						state <= ST_ACK;
						case (kind)
						K_ADDR: begin
							if (is_gc) begin
								kind <= K_GC;
								serial_data_pin_oe_n <= 1'b0;
							end else if (match7) begin
								kind <= shreg[0] ? K_READ : K_REG; // R5
								ten_ok <= 1'b0;
								serial_data_pin_oe_n <= 1'b0; // R17
							end else if (ten_first && !shreg[0]) begin
								kind <= K_ADDR2; // R5
								serial_data_pin_oe_n <= 1'b0;
							end else if (ten_first && ten_ok) begin
								kind <= K_READ; // R5
								serial_data_pin_oe_n <= 1'b0;
							end else begin
								state <= ST_IDLE; // R17
								kind <= K_NONE;
							end
						end
						K_ADDR2: begin
							if (ten_second) begin
								kind <= K_REG;
								ten_ok <= 1'b1;
								serial_data_pin_oe_n <= 1'b0; // R5
							end else begin
								state <= ST_IDLE; // R17
								kind <= K_NONE;
							end
						end
						K_REG: begin
							rd_addr <= shreg;
							kind <= K_DATA;
							serial_data_pin_oe_n <= 1'b0; // R14
						end
						K_DATA: begin
							if (fifo_in_ready) begin
								fifo_push <= 1'b1; // R20
								fifo_wdata <= {rd_addr, shreg}; // R1
								if (addr_steps(rd_addr))
									rd_addr <= rd_addr + 8'h01; // R3
								serial_data_pin_oe_n <= 1'b0; // R14
							end else begin
								// Stretch the clock until the queue has room; ack goes
								// low now, so data never moves once the clock is let go
								state <= ST_HOLD;
								scl_oe_n <= 1'b0;
								serial_data_pin_oe_n <= 1'b0; // R14 R15
							end
						end
						K_GC: begin
							if (gc_known) begin
								sel_relatch <= 1'b1; // R7
								serial_data_pin_oe_n <= 1'b0;
							end
							kind <= K_NONE;
						end
						default: begin
							state <= ST_IDLE;
							kind <= K_NONE;
						end
						endcase
					end
				end
				ST_HOLD: begin
					// Clock held low; back-pressure from the write queue
					if (fifo_in_ready) begin
						fifo_push <= 1'b1; // R20
						fifo_wdata <= {rd_addr, shreg};
						if (addr_steps(rd_addr))
							rd_addr <= rd_addr + 8'h01; // R3
						serial_data_pin_oe_n <= 1'b0; // R14
						scl_oe_n <= 1'b1;
						state <= ST_ACK;
					end
				end
				ST_ACK: begin
					// Ninth clock ends on its falling edge
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (kind == K_READ) begin
							txd <= rd_data;
							serial_data_pin_oe_n <= rd_data[7];
							rd_strobe <= 1'b1; // R19
							state <= ST_TX;
						end else if (kind == K_NONE) begin
							serial_data_pin_oe_n <= 1'b1;
							state <= ST_IDLE;
						end else begin
							serial_data_pin_oe_n <= 1'b1; // R14
							state <= ST_RX;
						end
					end
				end
				ST_TX: begin
					// Step after the strobe, so the strobe still shows the read address
					if (rd_strobe && addr_steps(rd_addr))
						rd_addr <= rd_addr + 8'h01; // R3 R19
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (byte_done) begin
							// Release for the master's acknowledge
							serial_data_pin_oe_n <= 1'b1; // R14
							state <= ST_MACK;
						end else begin
							txd <= {txd[6:0], 1'b0};
							serial_data_pin_oe_n <= txd[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						if (!sda_s2)
							state <= ST_ACK; // R19
						else
							state <= ST_IDLE; // R12
					end
				end
				default: begin
					state <= ST_IDLE;
					kind <= K_NONE;
				end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Write queue toward the register file
	// ------------------------------------------------------------
	i2cs_fifo #(
		.WIDTH(16),
		.DEPTH(`I2CS_FIFO_DEPTH),
		.AW(`I2CS_FIFO_AW)
	) u_fifo (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(fifo_push),
		.in_data(fifo_wdata),
		.in_ready(fifo_in_ready),
		.out_valid(wr_valid),
		.out_data(fifo_out),
		.out_ready(wr_ready)
	);

	assign wr_addr = fifo_out[15:8];
	assign wr_data = fifo_out[7:0];

endmodule

`default_nettype wire

// [verification/i2cs_inc.svh]
`ifndef I2CS_INC_SVH
`define I2CS_INC_SVH
// Register addresses that move on after each byte
function automatic logic i2cs_adv(input logic [7:0] a);
	return a <= 8'h07 || (a >= 8'h10 && a <= 8'h1f) || (a >= 8'h30 && a <= 8'h37)
		|| (a >= 8'h60 && a <= 8'h77) || (a >= 8'h80 && a <= 8'hbf);
endfunction
`endif

// [verification/i2cs_slave_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2cs_inc.svh"

module i2cs_slave_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Bus
	input wire logic scl_in,
	input wire logic scl_oe_n,
	input wire logic serial_data_pin_oe_n,
	// Register side
	input wire logic wr_valid,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_ready,
	input wire logic [7:0] rd_addr,
	input wire logic rd_strobe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [7:0] sa;
	// Address at the last read strobe, base for the step checks
	always @(posedge clk_sys) begin
		if (rd_strobe)
			sa <= rd_addr;
	end
	a_strobe_pulse: assert property (rd_strobe |=> !rd_strobe)
		else $error("read strobe too long");
	a_addr_fixed: assert property (rd_strobe && rd_addr >= 8'h38 && rd_addr <= 8'h3f |=> (rd_addr == sa)[*2])
		else $error("fixed address moved");
	a_addr_step: assert property (rd_strobe && i2cs_adv(rd_addr) |=> ##[0:1] rd_addr == sa + 8'h01)
		else $error("address did not advance by one");
	a_stretch_full: assert property (!scl_oe_n |-> wr_valid)
		else $error("clock held with room in buffer");
	a_stretch_end: assert property (!scl_oe_n && wr_ready |-> ##[1:4] scl_oe_n)
		else $error("clock held after room appeared");
	a_data_clk_low: assert property ($changed(serial_data_pin_oe_n) |-> !scl_in)
		else $error("data changed while clock high");
	a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
		else $error("write entry changed before taken");
	a_commit_ack: assert property ($rose(wr_valid) |-> !scl_in && !serial_data_pin_oe_n)
		else $error("byte stored without acknowledge");
endmodule
`default_nettype wire

// [verification/i2cs_host_model.sv]
`timescale 1ns/1ns
`default_nettype none

module i2cs_host_model (
	// Resolved bus levels
	input wire logic scl,
	input wire logic sda,
	// Master drive, 1 releases to the pull-up
	output var logic scl_m,
	output var logic sda_m
);
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// One bit: low 40 ns, high 24 ns; waits out a held clock
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		#16 scl_m = 1'b1;
		for (int k = 0; k < 5000 && scl !== 1'b1; k++) #8;
		r = sda;
		#24 scl_m = 1'b0;
		#24;
	endtask
	task automatic start();
		sda_m = 1'b1;
		#20 scl_m = 1'b1;
		#20 sda_m = 1'b0;
		#20 scl_m = 1'b0;
		#24;
	endtask
	task automatic stop();
		sda_m = 1'b0;
		#20 scl_m = 1'b1;
		#20 sda_m = 1'b1;
		#40;
	endtask
	// Byte out, line released on the ninth clock for the answer
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(nack, r);
	endtask
	// Clocks a byte without any start first
	task automatic stray(input logic [7:0] b, output logic ack);
		scl_m = 1'b0;
		#40;
		wbyte(b, ack);
	endtask
endmodule
`default_nettype wire

// [verification/i2c_slave_register_access_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "i2cs_inc.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end

module i2c_slave_register_access_tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic wr_ready = 1'b0;
	logic hold = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [2:0] pins = 3'h0;
	logic [6:0] adr = 7'h40;
	logic ack;
	logic [7:0] rb;
	logic [15:0] ev;
	logic [15:0] exp_q[$];
	int mismatches = 0;
	int tests_run = 0;
	wire scl_m, sda_m, scl_oe_n, sda_oe_n, wr_valid, rd_strobe;
	wire [7:0] wr_addr, wr_data, rd_addr, rd_data;
	// Open-drain wires with pull-ups
	wire scl = scl_m & scl_oe_n;
	wire sda = sda_m & sda_oe_n;
	// Register file stand-in: data is a fixed pattern of the address
	assign rd_data = rd_addr ^ 8'ha5;

	always #4 clk_sys = ~clk_sys;
	// Random consumer pace keeps the buffer moving at odd rates
	always @(posedge clk_sys) wr_ready <= !hold && ($urandom % 4 != 0);

	i2cs_slave DUT (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl), .scl_oe_n(scl_oe_n),
		.serial_data_pin_in(sda), .serial_data_pin_oe_n(sda_oe_n),
		.addr_select_bit2(pins[2]), .addr_select_bit1(pins[1]), .addr_select_bit0(pins[0]),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data));
	i2cs_host_model m (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m));

	// Each accepted entry is matched against the oldest note
	always @(posedge clk_sys) begin
		if (nrst && wr_valid === 1'b1 && wr_ready) begin
			if (exp_q.size() == 0)
				`CHK(1'b1, 1'b0)
			else begin
				ev = exp_q.pop_front();
				`CHK({wr_addr, wr_data}, ev)
			end
		end
	end

	function automatic logic [7:0] nx(input logic [7:0] a);
		return i2cs_adv(a) ? a + 8'h01 : a;
	endfunction
	task automatic summarize();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Addresses the device, short or long form, and sets the register
	task automatic open_at(input logic ten, input logic [7:0] ra);
		m.start();
		if (ten) begin
			m.wbyte(8'hf0, ack);
			m.wbyte({5'h08, sel}, ack);
		end else
			m.wbyte({adr, 1'b0}, ack);
		`CHK(ack, 1'b0)
		m.wbyte(ra, ack);
		`CHK(ack, 1'b0)
	endtask
	task automatic wr(input logic ten, input logic [7:0] ra, input int n);
		logic [7:0] d;
		open_at(ten, ra);
		repeat (n) begin
			d = $urandom;
			exp_q.push_back({ra, d});
			m.wbyte(d, ack);
			`CHK(ack, 1'b0)
			ra = nx(ra);
		end
		m.stop();
	endtask
	task automatic rd(input logic ten, input logic [7:0] ra, input int n);
		open_at(ten, ra);
		m.start();
		m.wbyte(ten ? 8'hf1 : {adr, 1'b1}, ack);
		`CHK(ack, 1'b0)
		for (int i = 1; i <= n; i++) begin
			m.rbyte(i == n, rb);
			`CHK(rb, ra ^ 8'ha5)
			ra = nx(ra);
		end
		m.stop();
	endtask

	// Hang guard
	initial begin
		#400000;
		mismatches++;
		summarize();
	end
	initial begin
		void'($urandom(32'hd26c595f));
		sel = $urandom;
		pins = sel;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		pins <= ~sel;
		adr <= {4'h8, sel};
		repeat (4) @(posedge clk_sys);
		wr(1'b0, 8'h3e, 3);
		wr(1'b0, 8'h06, 4);
		wr(1'b0, 8'hbf, 2);
		wr(1'b1, 8'h30, 2);
		rd(1'b0, 8'h37, 3);
		rd(1'b0, 8'h1e, 3);
		rd(1'b1, 8'h6e, 3);
		// Address from the pins' present level must not answer
		m.start();
		m.wbyte({4'h8, ~sel, 1'b0}, ack);
		`CHK(ack, 1'b1)
		m.wbyte(8'h10, ack);
		`CHK(ack, 1'b1)
		m.stop();
		m.stray({adr, 1'b0}, ack);
		`CHK(ack, 1'b1)
		// Fill the buffer until the clock is held, then drain
		hold <= 1'b1;
		fork
			wr(1'b0, 8'h39, 18);
			begin
				for (int k = 0; k < 20000 && scl_oe_n !== 1'b0; k++) @(posedge clk_sys);
				`CHK(scl_oe_n, 1'b0)
				repeat (50) @(posedge clk_sys);
				hold <= 1'b0;
			end
		join
		for (int k = 0; k < 2000 && exp_q.size() != 0; k++) @(posedge clk_sys);
		`CHK(exp_q.size(), 0)
		// General call: unknown code refused, then 06 takes the pins' new level
		m.start();
		m.wbyte(8'h00, ack);
		`CHK(ack, 1'b0)
		m.wbyte(8'h0a, ack);
		`CHK(ack, 1'b1)
		m.stop();
		m.start();
		m.wbyte(8'h00, ack);
		m.wbyte(8'h06, ack);
		`CHK(ack, 1'b0)
		m.stop();
		m.start();
		m.wbyte({4'h8, ~sel, 1'b0}, ack);
		`CHK(ack, 1'b0)
		m.stop();
		summarize();
	end
endmodule

bind i2cs_slave i2cs_slave_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_in),
	.scl_oe_n(scl_oe_n), .serial_data_pin_oe_n(serial_data_pin_oe_n), .wr_valid(wr_valid),
	.wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .rd_addr(rd_addr),
	.rd_strobe(rd_strobe));
`default_nettype wire
